/* hdl/simu_core.sv */
// Purpose: Smart-card mode of an asynchronous serial channel
// Assumes: Internal baud clock only; divisor n gives bit time 16*(n+1) cycles
// Notes:   Control bits are plain ports; two-entry buffer on receive data path
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1 - Direct or inverse convention by three settings
// RULE2 - Low on output after receive parity error
// RULE3 - Software uses internal clock, divisor any
// RULE4 - Handshake disabled by software, ignored here
// RULE5 - Transmit starts when enabled and buffer full
// RULE6 - Receive starts when enabled and start seen
// RULE7 - Transmit request when shifting finished
// RULE8 - Receive request when character reaches buffer
// RULE9 - Overrun when eighth bit arrives unread; here only once the two-entry buffer is also full
// RULE10 - Overrun leaves buffer undefined, no request
// RULE11 - Framing error when stop bit missing
// RULE12 - Parity error on ones count mismatch
// RULE13 - Error sum set on any error
// RULE14 - Error signal only when enabled
// RULE15 - Error signal only for parity error
// RULE16 - Buffer read ends error signal, clears flag
// RULE17 - Software checks error signal via input pin
// RULE18 - Direct sends uninverted, even, D0 first
// RULE19 - Direct stores uninverted, D0 first, even
// RULE20 - Inverse sends inverted, odd, D7 first
// RULE21 - Inverse stores inverted, D7 first
// RULE22 - Inverse checks odd parity
// RULE23 - Error low during stop bit period
module simu_core
  import simu_pkg::*;
#(
  parameter int DATA_W = simu_pkg::SIMU_DATA_W
) (
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  input  wire logic [simu_pkg::SIMU_DIV_W-1:0] baud_divisor,
  input  wire logic                         transmit_enable,
  input  wire logic                         receive_enable,
  input  wire logic                         parity_odd_even,
  input  wire logic                         bit_order_select,
  input  wire logic                         logic_invert,
  input  wire logic                         error_signal_enable,
  input  wire logic [DATA_W-1:0]            tx_buffer,
  input  wire logic                         tx_write,
  input  wire logic                         rx_read,
  input  wire logic                         serial_in_pin,
  output logic                              serial_out_pin,
  output logic                              serial_out_oe,
  output logic                              tx_buffer_empty,
  output logic                              tx_idle,
  output logic                              tx_irq,
  output logic                              rx_irq,
  output logic [DATA_W-1:0]                 rx_buffer,
  output logic                              rx_complete,
  output logic                              overrun_flag,
  output logic                              framing_error_flag,
  output logic                              parity_error_flag,
  output logic                              error_sum_flag
);
  import simu_pkg::*;

  // Oversampling tick from the divisor, sixteen per bit time
  logic [SIMU_DIV_W-1:0] div_r;
  logic                  tick;
  assign tick = (div_r == '0);
  always_ff @(posedge clk_sys) begin
    if (!nrst || tick) begin
      div_r <= baud_divisor;
    end else begin
      div_r <= div_r - 1'b1;
    end
  end

  // Receive pin synchroniser; stage one feeds only stage two
  logic rx_s1_r;
  logic rx_s2_r;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= serial_in_pin;
      rx_s2_r <= rx_s1_r;
    end
  end

  function automatic logic [DATA_W-1:0] rev(input logic [DATA_W-1:0] d);
    for (int i = 0; i < DATA_W; i++) begin
      rev[i] = d[DATA_W-1-i];
    end
  endfunction

  // Transmit holding buffer and character forming
  logic [DATA_W-1:0] thr_r;
  logic [DATA_W-1:0] tx_char;
  logic              tx_par;
  logic              tx_load;
  assign tx_char = rev_sel(thr_r);
  function automatic logic [DATA_W-1:0] rev_sel(input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] v;
    v = logic_invert ? ~d : d; // RULE18 RULE20
    rev_sel = bit_order_select ? rev(v) : v; // RULE1
  endfunction
  // Even parity sets ones even; odd sets them odd
  assign tx_par = (^tx_char) ^ ~parity_odd_even; // RULE18 RULE20

  simu_st_e          tx_st_r;
  logic [3:0]        tx_ovs_r;
  logic [3:0]        tx_bit_r;
  logic [DATA_W:0]   tx_sh_r;
  logic              tx_line_r;
  logic              tx_done;
  assign tx_load = (tx_st_r == SIMU_IDLE) && tick && transmit_enable && !tx_buffer_empty; // RULE5
  assign tx_done = (tx_st_r == SIMU_STOP) && tick && (tx_ovs_r == SIMU_OVS_LAST);

  property p_tx_start_cond;
    @(posedge clk_sys) disable iff (!nrst)
      (tx_st_r == SIMU_START) && ($past(tx_st_r) == SIMU_IDLE)
        |-> $past(transmit_enable) && !$past(tx_buffer_empty);
  endproperty
  a_tx_start_cond: assert property (p_tx_start_cond) else $error("start w/o data"); // RULE5

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      thr_r           <= '0;
      tx_buffer_empty <= 1'b1;
    end else if (tx_write) begin
      thr_r           <= tx_buffer;
      tx_buffer_empty <= 1'b0;
    end else if (tx_load) begin
      tx_buffer_empty <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tx_st_r   <= SIMU_IDLE;
      tx_ovs_r  <= '0;
      tx_bit_r  <= '0;
      tx_sh_r   <= '0;
      tx_line_r <= 1'b1;
    end else if (tx_load) begin
      tx_st_r   <= SIMU_START;
      tx_ovs_r  <= '0;
      tx_sh_r   <= {tx_par, tx_char};
      tx_line_r <= 1'b0;
    end else if (tick && tx_st_r != SIMU_IDLE) begin
      tx_ovs_r <= tx_ovs_r + 1'b1;
      if (tx_ovs_r == SIMU_OVS_LAST) begin
        unique case (tx_st_r)
          SIMU_START: begin
            tx_st_r   <= SIMU_DATA;
            tx_bit_r  <= '0;
            tx_line_r <= tx_sh_r[0];
            tx_sh_r   <= tx_sh_r >> 1;
          end
          SIMU_DATA: begin
            if (tx_bit_r == SIMU_BIT_LAST) begin
              tx_st_r   <= SIMU_STOP;
              tx_line_r <= 1'b1;
            end else begin
              tx_bit_r  <= tx_bit_r + 1'b1;
              tx_line_r <= tx_sh_r[0];
              tx_sh_r   <= tx_sh_r >> 1;
            end
          end
          SIMU_STOP: begin
            tx_st_r <= SIMU_IDLE;
          end
          SIMU_IDLE: begin
            tx_st_r <= SIMU_IDLE;
          end
        endcase
      end
    end
  end

  // Receiver
  simu_st_e        rx_st_r;
  logic [3:0]      rx_ovs_r;
  logic [3:0]      rx_bit_r;
  logic [DATA_W:0] rx_sh_r;
  logic            rx_mid;
  logic            rx_end;
  logic            rx_perr;
  logic [DATA_W-1:0] rx_data;
  assign rx_mid  = tick && (rx_ovs_r == SIMU_OVS_MID);
  assign rx_end  = (rx_st_r == SIMU_STOP) && rx_mid;
  // Count of ones over data and parity must be even (direct) or odd (inverse)
  assign rx_perr = (^rx_sh_r) == parity_odd_even; // RULE12 RULE19 RULE22
  assign rx_data = rev_sel(rx_sh_r[DATA_W-1:0]); // RULE19 RULE21

  property p_rx_start_cond;
    @(posedge clk_sys) disable iff (!nrst)
      (rx_st_r == SIMU_START) && ($past(rx_st_r) == SIMU_IDLE) |-> $past(receive_enable);
  endproperty
  a_rx_start_cond: assert property (p_rx_start_cond) else $error("rx start disabled"); // RULE6

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_st_r  <= SIMU_IDLE;
      rx_ovs_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r  <= '0;
    end else if (rx_st_r == SIMU_IDLE) begin
      rx_ovs_r <= '0;
      if (receive_enable && !rx_s2_r) begin
        rx_st_r <= SIMU_START; // RULE6
      end
    end else if (tick) begin
      rx_ovs_r <= (rx_ovs_r == SIMU_OVS_LAST) ? '0 : rx_ovs_r + 1'b1;
      if (rx_mid) begin
        unique case (rx_st_r)
          SIMU_START: begin
            rx_st_r  <= rx_s2_r ? SIMU_IDLE : SIMU_DATA;
            rx_bit_r <= '0;
          end
          SIMU_DATA: begin
            rx_sh_r  <= {rx_s2_r, rx_sh_r[DATA_W:1]};
            rx_bit_r <= rx_bit_r + 1'b1;
            if (rx_bit_r == SIMU_BIT_LAST) begin
              rx_st_r <= SIMU_STOP;
            end
          end
          SIMU_STOP: begin
            rx_st_r <= SIMU_IDLE;
          end
          SIMU_IDLE: begin
            rx_st_r <= SIMU_IDLE;
          end
        endcase
      end
    end
  end

  // Eighth data bit of next character while buffer unread
  logic rx_eighth;
  assign rx_eighth = (rx_st_r == SIMU_DATA) && rx_mid && (rx_bit_r == SIMU_BIT_EIGHT);

  // Two-entry buffer between receive shifter and rx_buffer; entry 0 is head
  logic [DATA_W+1:0] fb_r [2];
  logic [1:0]        fb_cnt_r;
  logic              fb_push;
  logic              fb_pop;
  logic              fb_ready;
  logic              ovr_pend_r;
  assign fb_ready = (fb_cnt_r != 2'h2);
  assign fb_push  = rx_end && fb_ready && !ovr_pend_r; // RULE10
  assign fb_pop   = (fb_cnt_r != 2'h0) && (!rx_complete || rx_read);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fb_cnt_r <= '0;
      fb_r[0]  <= '0;
      fb_r[1]  <= '0;
    end else begin
      fb_cnt_r <= fb_cnt_r + {1'b0, fb_push} - {1'b0, fb_pop};
      if (fb_pop) begin
        fb_r[0] <= fb_r[1];
      end
      if (fb_push) begin
        fb_r[(fb_pop ? fb_cnt_r - 2'h1 : fb_cnt_r) == 2'h0 ? 0 : 1] <=
          {rx_perr, !rx_s2_r, rx_data};
      end
    end
  end

  // Overrun: buffer full while unread and next eighth bit lands
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ovr_pend_r <= 1'b0;
    end else if (rx_eighth && rx_complete && !rx_read && !fb_ready) begin
      ovr_pend_r <= 1'b1; // RULE9
    end else if (rx_end || rx_st_r == SIMU_IDLE) begin
      ovr_pend_r <= 1'b0;
    end
  end

  // Visible receive buffer and flags; a new event beats the read clear
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_buffer          <= '0;
      rx_complete        <= 1'b0;
      rx_irq             <= 1'b0;
      overrun_flag       <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
      error_sum_flag     <= 1'b0;
    end else begin
      rx_irq <= fb_pop; // RULE8
      if (fb_pop) begin
        rx_buffer          <= fb_r[0][DATA_W-1:0];
        rx_complete        <= 1'b1;
        framing_error_flag <= fb_r[0][DATA_W]; // RULE11
        parity_error_flag  <= fb_r[0][DATA_W+1]; // RULE12
      end else if (rx_read) begin
        rx_complete        <= 1'b0;
        framing_error_flag <= 1'b0;
        parity_error_flag  <= 1'b0; // RULE16
      end
      if (rx_end && ovr_pend_r) begin
        overrun_flag <= 1'b1; // RULE9 RULE10
      end else if (rx_read) begin
        overrun_flag <= 1'b0;
      end
      if ((rx_end && ovr_pend_r) || (fb_pop && |fb_r[0][DATA_W+1:DATA_W])) begin
        error_sum_flag <= 1'b1; // RULE13
      end else if (rx_read) begin
        error_sum_flag <= 1'b0;
      end
    end
  end

  // Error low from parity error for the rest of the stop period or until buffer read;
  // its own tick counter, since the receiver's counter is parked while idle
  logic       err_sig_r;
  logic       err_start;
  logic [3:0] err_cnt_r;
  assign err_start = rx_end && rx_perr && error_signal_enable; // RULE2 RULE14 RULE15 RULE23
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      err_sig_r <= 1'b0;
      err_cnt_r <= '0;
    end else if (err_start) begin
      err_sig_r <= 1'b1;
      err_cnt_r <= '0;
    end else if (rx_read || (tick && err_cnt_r == SIMU_OVS_MID)) begin
      err_sig_r <= 1'b0; // RULE16 RULE23
    end else if (tick && err_sig_r) begin
      err_cnt_r <= err_cnt_r + 1'b1;
    end
  end

  // Open-drain output: drive only when low; float otherwise so pull-up wins
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      serial_out_pin <= 1'b1;
      serial_out_oe  <= 1'b0;
      tx_irq         <= 1'b0;
      tx_idle        <= 1'b1;
    end else begin
      serial_out_pin <= tx_line_r && !err_sig_r;
      serial_out_oe  <= !(tx_line_r && !err_sig_r); // RULE23
      tx_irq         <= tx_done; // RULE7
      tx_idle        <= (tx_st_r == SIMU_IDLE) && !tx_load;
    end
  end

  property p_err_only_parity;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(err_sig_r) |-> $past(rx_perr) && $past(error_signal_enable);
  endproperty
  a_err_only_parity: assert property (p_err_only_parity) else $error("error low w/o parity"); // RULE15

  sequence s_err_begin;
    err_start;
  endsequence
  sequence s_pin_low;
    serial_out_oe && !serial_out_pin;
  endsequence
  property p_err_drives_low;
    @(posedge clk_sys) disable iff (!nrst)
      s_err_begin |=> ##1 s_pin_low;
  endproperty
  a_err_drives_low: assert property (p_err_drives_low) else $error("error low missing"); // RULE23

  property p_err_read_ends;
    @(posedge clk_sys) disable iff (!nrst)
      err_sig_r && rx_read && !err_start |=> !err_sig_r;
  endproperty
  a_err_read_ends: assert property (p_err_read_ends) else $error("read kept error low"); // RULE16

  property p_err_sum;
    @(posedge clk_sys) disable iff (!nrst)
      overrun_flag || framing_error_flag || parity_error_flag |-> error_sum_flag;
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("error sum not set"); // RULE13
endmodule // simu_core

`default_nettype wire

/* common/simu_pkg.sv */
// Purpose: Constants for the smart-card serial channel
// Assumes: 100 MHz system clock
// Notes:   Shared by the design and its bench
package simu_pkg;
  localparam int          SIMU_DATA_W    = 8;
  localparam int          SIMU_DIV_W     = 8;
  localparam int          SIMU_OVS       = 16;
  localparam logic [3:0]  SIMU_OVS_LAST  = 4'hf;
  localparam logic [3:0]  SIMU_OVS_MID   = 4'h7;
  localparam logic [3:0]  SIMU_BIT_LAST  = 4'h8;
  localparam logic [3:0]  SIMU_BIT_EIGHT = 4'h7;
  localparam logic [7:0]  SIMU_DIV_RST   = 8'h00;
  typedef enum logic [1:0] {
    SIMU_IDLE  = 2'b00,
    SIMU_START = 2'b01,
    SIMU_DATA  = 2'b10,
    SIMU_STOP  = 2'b11
  } simu_st_e;
endpackage

/* dv/simu_card.sv */
// Purpose: Smart-card model on the serial lines
// Assumes: Divisor 0, so one bit lasts 16 clk_sys cycles
// Notes:   Line pulled up when nobody drives it
`timescale 1ns/1ps
`default_nettype none
module simu_card (
  input  wire logic clk_sys,
  input  wire logic card_rx,
  output logic      card_tx
);
  localparam int BT = 16;
  logic err_low;
  initial begin
    card_tx = 1'b1;
    err_low = 1'b0;
  end
  task automatic bits(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Nine bits in wire order, then the given stop level
  task automatic send(input logic [8:0] v, input logic stop);
    card_tx = 1'b0;
    bits(BT);
    for (int i = 0; i < 9; i++) begin
      card_tx = v[i];
      bits(BT);
    end
    card_tx = stop;
    bits(12);
    err_low = ~card_rx;
    card_tx = 1'b1;
    bits(4 + BT);
  endtask
  task automatic get(output logic [8:0] v, output logic stop);
    for (int k = 0; k < 4000 && card_rx; k++) @(posedge clk_sys);
    bits(BT / 2);
    for (int i = 0; i < 9; i++) begin
      bits(BT);
      v[i] = card_rx;
    end
    bits(BT);
    stop = card_rx;
  endtask
endmodule // simu_card
`default_nettype wire

/* dv/testbench.sv */
// Purpose: Self-checking bench for the smart-card serial channel
// Assumes: Divisor 0; inputs change 1 ns after the rising edge
// Notes:   Both conventions are run in each direction
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import simu_pkg::*;
  logic       clk_sys = 1'b0, nrst = 1'b0, tx_write, rx_read, stp;
  logic       transmit_enable, receive_enable, error_signal_enable;
  logic       parity_odd_even, bit_order_select, logic_invert, serial_in_pin;
  logic       serial_out_pin, serial_out_oe, tx_buffer_empty, tx_idle, tx_irq, rx_irq;
  logic       rx_complete, overrun_flag, framing_error_flag, parity_error_flag, error_sum_flag;
  logic [7:0] baud_divisor, tx_buffer, rx_buffer;
  logic [8:0] w;
  int         miscompares = 0, n_tests = 0, cycles = 0, n_txirq = 0, n_rxirq = 0;
  // Open drain with pull-up: released line reads high
  wire logic  tx_line = serial_out_oe ? serial_out_pin : 1'b1;
  always #5 clk_sys = ~clk_sys;
  simu_core u_dut (.clk_sys, .nrst, .baud_divisor, .transmit_enable, .receive_enable,
    .parity_odd_even, .bit_order_select, .logic_invert, .error_signal_enable, .tx_buffer,
    .tx_write, .rx_read, .serial_in_pin, .serial_out_pin, .serial_out_oe, .tx_buffer_empty,
    .tx_idle, .tx_irq, .rx_irq, .rx_buffer, .rx_complete, .overrun_flag, .framing_error_flag,
    .parity_error_flag, .error_sum_flag);
  simu_card u_card (.clk_sys, .card_rx(tx_line), .card_tx(serial_in_pin));
  task automatic finish_test();
    $display("Comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    n_txirq += int'(tx_irq === 1'b1);
    n_rxirq += int'(rx_irq === 1'b1);
    if (cycles == 8000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd();
    rx_read = 1'b1;
    step(1);
    rx_read = 1'b0;
    step(3);
  endtask
  // Wire order: bit 0 goes first, bit 8 is parity
  function automatic logic [8:0] wire_of(input logic [7:0] d, input logic inv);
    logic [7:0] v;
    for (int i = 0; i < 8; i++) v[i] = inv ? ~d[7-i] : d[i];
    return {^v ^ inv, v};
  endfunction
  task automatic fmt(input logic inv);
    parity_odd_even = ~inv;
    bit_order_select = inv;
    logic_invert = inv;
  endtask
  task automatic tx(input logic [7:0] d, input logic inv);
    int n0;
    n0 = n_txirq;
    tx_buffer = d;
    tx_write = 1'b1;
    step(1);
    tx_write = 1'b0;
    if (!transmit_enable) begin
      step(50);
      check({tx_line, tx_buffer_empty}, 9'h2);
      transmit_enable = 1'b1;
    end
    u_card.get(w, stp);
    check({stp, w}, {1'h1, wire_of(d, inv)});
    step(40);
    check(9'(n_txirq - n0), 9'h1);
  endtask
  task automatic rx(input logic [8:0] v, input logic stop, input logic [7:0] d,
                    input logic pe, input logic err);
    int n0;
    n0 = n_rxirq;
    u_card.send(v, stop);
    check({rx_complete, rx_buffer}, {1'h1, d});
    check(parity_error_flag, pe);
    check(framing_error_flag, !stop);
    check(error_sum_flag, pe | !stop);
    check(u_card.err_low, err);
    check(9'(n_rxirq - n0), 9'h1);
    rd();
    check({parity_error_flag, tx_line, rx_complete}, 9'h2);
  endtask
  initial begin
    int n0;
    {transmit_enable, receive_enable, error_signal_enable, tx_write, rx_read} = 5'h0;
    baud_divisor = 8'h00;
    // No handshake lines exist, so none are driven
    tx_buffer = 8'h00;
    fmt(1'h0);
    step(8);
    nrst = 1'b1;
    check({tx_line, serial_out_oe, tx_buffer_empty, tx_idle, rx_complete, overrun_flag,
           framing_error_flag, parity_error_flag, error_sum_flag}, 9'h160);
    tx(8'h2c, 1'h0);
    fmt(1'h1);
    tx(8'h2c, 1'h1);
    u_card.send(wire_of(8'h5a, 1'h1), 1'h1);
    check(rx_complete, 1'h0);
    receive_enable = 1'b1;
    error_signal_enable = 1'b1;
    for (int f = 0; f < 2; f++) begin
      fmt(f[0]);
      rx(wire_of(8'h2c, f[0]), 1'h1, 8'h2c, 1'h0, 1'h0);
      rx(wire_of(8'hc5, f[0]) ^ 9'h100, 1'h1, 8'hc5, 1'h1, 1'h1);
    end
    error_signal_enable = 1'b0;
    rx(wire_of(8'h96, 1'h1) ^ 9'h100, 1'h1, 8'h96, 1'h1, 1'h0);
    rx(wire_of(8'h0f, 1'h1), 1'h0, 8'h0f, 1'h0, 1'h0);
    // Three characters fill the buffer; the fourth overruns
    n0 = n_rxirq;
    for (int k = 1; k < 5; k++) u_card.send(wire_of(8'(8'h11 * k), 1'h1), 1'h1);
    check({overrun_flag, error_sum_flag}, 9'h3);
    // Only the first reaches the visible buffer; the overrun one never requests
    check(9'(n_rxirq - n0), 9'h1);
    for (int k = 2; k < 4; k++) begin
      rd();
      check(rx_buffer, 9'(8'h11 * k));
    end
    rd();
    check(rx_complete, 1'h0);
    check(9'(n_rxirq - n0), 9'h3);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
